// ===== usb_irq_pkg.sv
// constants, types and register map of the usb microcontroller interrupt controller
// assumes one 20 MHz clock; registers reached over apb, one word per register index
//
// Function
// - smallest pending enabled vector number wins; vector 1 highest, 12 lowest
// - after reset the first fetch is from program address 0x0000
// - each vector slot spans two bytes, one jump instruction
// - vector addresses 0x0002 to 0x0018 in vector order, 0x0012 reserved
// - read-only vector register gives top pending enabled address in bits 4:1
// - entry takes remaining cycles plus 10 call plus 5 jump cycles
// - bus reset is an se0 held 12 us, always seen beyond 16 us
// - recognised bus reset sets status bit 5; interrupt raised when se0 ends
// - bus reset during the power-up start-up delay aborts that delay
// - bus reset clears both device address registers of the usb engine
// - two periodic ticks: every 128 us and every 1.024 ms
// - one interrupt per endpoint, raised on the final handshake
// - an in transaction without host acknowledge raises nothing
// - current-sink pins trigger on an edge of programmable polarity when enabled
// - after one sink pin triggers, others blocked until it goes inactive or disabled
// - sink pins are not ranked; their enables survive acknowledge
// - port pins share one vector, edge polarity per port, same blocking
// - port pins are not ranked; port enables survive acknowledge
// - parallel port owns the port vector, blocks port pins, gated by bit 5
// - port pin enables still reach the cmos output logic in parallel mode
// - each source has a pending flop; requests only when enabled
// - acknowledge clears global enable, then pending flop, then calls the vector
// - enables live in the global and endpoint enable registers, one enables
package usb_irq_pkg;
  localparam int CLK_MHZ = 20;
  localparam int SE0_MIN_NS = 12000;
  localparam int SE0_MAX_NS = 16000;
  localparam int TICK_NS = 128000;
  localparam int MS_TICKS = 8;
  localparam int CALL_CYC = 10;
  localparam int JUMP_CYC = 5;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_GIE = 8'h20;
  localparam logic [7:0] IDX_EPE = 8'h21;
  localparam logic [7:0] IDX_VEC = 8'h23;
  localparam logic [7:0] IDX_STAT = 8'h24;
  localparam logic [7:0] IDX_CFG = 8'h25;
  localparam logic [7:0] IDX_SINKE = 8'h26;
  localparam logic [7:0] IDX_SINKP = 8'h27;
  localparam logic [7:0] IDX_PORTE = 8'h28;
  localparam logic [7:0] GIE_MASK = 8'h77;
  localparam logic [7:0] EPE_MASK = 8'h1f;
  localparam int GE_BUSRST = 0;
  localparam int GE_T128 = 1;
  localparam int GE_T1MS = 2;
  localparam int GE_SINK = 4;
  localparam int GE_PORT = 5;
  localparam int GE_I2C = 6;
  localparam int ST_IRQ = 7;
  localparam int ST_BUSRST = 5;
  localparam int ST_GIE = 2;
  localparam int CF_PAR = 0;
  localparam int CF_PPOL = 1;
  // vector numbers
  localparam int V_BUSRST = 1;
  localparam int V_T128 = 2;
  localparam int V_T1MS = 3;
  localparam int V_EP0 = 4;
  localparam int V_SINK = 10;
  localparam int V_PORT = 11;
  localparam int V_I2C = 12;
  localparam int NVEC = 12;
  localparam logic [13:0] RESET_ADDR = 14'h0000;
  typedef struct packed {
    logic valid;
    logic [13:0] addr;
  } fetch_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALL = 2'b01,
    ST_JUMP = 2'b10
  } ack_st_t;
endpackage

// ===== usb_irq_ctrl.sv
// interrupt controller: pending flops, fixed priority, vector and acknowledge sequencing
// assumes core, usb engine, timers and serial logic on i_sys_clk; pins are asynchronous
module usb_irq_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_usb_dp,
  input wire logic i_usb_dm,
  input wire logic i_startup_busy,
  output logic o_dev_addr_clr,
  output logic o_startup_abort,
  input wire logic [4:0] i_ep_host_ack,
  input wire logic [4:0] i_ep_dev_ack,
  input wire logic i_i2c_evt,
  input wire logic i_par_evt,
  input wire logic [7:0] i_sink_pin,
  input wire logic [7:0] i_port_pin,
  output logic [7:0] o_port_int_en,
  input wire logic i_instr_done,
  input wire logic i_gie_set,
  input wire logic i_gie_clr,
  output logic o_gie,
  output logic o_irq_req,
  output logic o_call_push,
  output usb_irq_pkg::fetch_t o_fetch,
  output logic o_isr_start
);
  localparam int TICK_CYC = usb_irq_pkg::TICK_NS * usb_irq_pkg::CLK_MHZ / 1000;
  localparam int SE0_CYC = (usb_irq_pkg::SE0_MIN_NS * usb_irq_pkg::CLK_MHZ + 999) / 1000;
  localparam int SE0_MAX_CYC = usb_irq_pkg::SE0_MAX_NS * usb_irq_pkg::CLK_MHZ / 1000;

  // highest priority request: smallest vector number, 0 when none
  function automatic logic [3:0] first_vec(input logic [11:0] req);
    logic [3:0] v;
    v = 4'h0;
    for (int i = usb_irq_pkg::NVEC - 1; i >= 0; i--) begin
      if (req[i]) begin
        v = 4'(i + 1);
      end
    end
    return v;
  endfunction

  // word address match for one register index
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction

  // pins that still hold a group lock: triggered, at trigger level, still enabled
  function automatic logic [7:0] held(input logic [7:0] lock, input logic [7:0] lvl,
                                      input logic [7:0] en);
    return lock & lvl & en;
  endfunction

  logic [7:0] gie_en_r;
  logic [7:0] ep_en_r;
  logic [7:0] sink_en_r;
  logic [7:0] sink_pol_r;
  logic [7:0] port_en_r;
  logic par_en_r;
  logic port_pol_r;
  logic busrst_flag_r;
  logic gie_r;
  logic [11:0] pend_r;
  logic [11:0] en_vec;
  logic [11:0] req;
  logic [11:0] evt;
  logic [11:0] pend_clr;
  logic [3:0] top_vec;
  logic [3:0] win_r;
  logic [3:0] cnt_r;
  usb_irq_pkg::ack_st_t st_r;
  logic take;
  logic wr_acc;
  logic [7:0] wd;
  logic [7:0] rd;
  logic rd_ok;
  logic rst_done_r;

  // two-flop synchronisers for every pin input
  logic [1:0] dp_s_r;
  logic [1:0] dm_s_r;
  logic [7:0] sink_s1_r;
  logic [7:0] sink_s2_r;
  logic [7:0] port_s1_r;
  logic [7:0] port_s2_r;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dp_s_r <= 2'b11;
      dm_s_r <= 2'b00;
      sink_s1_r <= 8'h00;
      sink_s2_r <= 8'h00;
      port_s1_r <= 8'h00;
      port_s2_r <= 8'h00;
    end else begin
      dp_s_r <= {dp_s_r[0], i_usb_dp};
      dm_s_r <= {dm_s_r[0], i_usb_dm};
      sink_s1_r <= i_sink_pin;
      sink_s2_r <= sink_s1_r;
      port_s1_r <= i_port_pin;
      port_s2_r <= port_s1_r;
    end
  end

  // se0 duration counter; recognition at the 12 us mark, well inside 16 us
  logic se0;
  logic se0_seen_r;
  logic [8:0] se0_cnt_r;
  logic busrst_hit;
  logic busrst_end;
  assign se0 = !dp_s_r[1] && !dm_s_r[1];
  assign busrst_hit = se0 && !se0_seen_r && (int'(se0_cnt_r) == SE0_CYC - 1);
  assign busrst_end = se0_seen_r && !se0;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      se0_cnt_r <= 9'h000;
      se0_seen_r <= 1'b0;
      o_dev_addr_clr <= 1'b0;
      o_startup_abort <= 1'b0;
    end else begin
      if (!se0) begin
        se0_cnt_r <= 9'h000;
      end else if (int'(se0_cnt_r) < SE0_MAX_CYC) begin
        se0_cnt_r <= se0_cnt_r + 9'h001;
      end
      if (busrst_hit) begin
        se0_seen_r <= 1'b1;
      end else if (!se0) begin
        se0_seen_r <= 1'b0;
      end
      o_dev_addr_clr <= busrst_hit;
      o_startup_abort <= busrst_hit && i_startup_busy;
    end
  end

  // 128 us tick and every eighth of them the 1.024 ms tick
  logic [11:0] tick_cnt_r;
  logic [2:0] ms_cnt_r;
  logic tick128;
  logic tick1ms;
  assign tick128 = int'(tick_cnt_r) == TICK_CYC - 1;
  assign tick1ms = tick128 && (int'(ms_cnt_r) == usb_irq_pkg::MS_TICKS - 1);
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt_r <= 12'h000;
      ms_cnt_r <= 3'h0;
    end else begin
      tick_cnt_r <= tick128 ? 12'h000 : tick_cnt_r + 12'h001;
      if (tick128) begin
        ms_cnt_r <= ms_cnt_r + 3'h1;
      end
    end
  end

  // sink and port pin edge logic with a shared-vector lock per group
  logic [7:0] sink_lvl;
  logic [7:0] sink_lvl_d_r;
  logic [7:0] sink_lock_r;
  logic [7:0] sink_edge;
  logic [7:0] port_lvl;
  logic [7:0] port_lvl_d_r;
  logic [7:0] port_lock_r;
  logic [7:0] port_edge;
  logic [7:0] port_en_eff;
  logic sink_fire;
  logic port_fire;
  assign sink_lvl = ~(sink_s2_r ^ sink_pol_r);
  assign sink_edge = sink_lvl & ~sink_lvl_d_r & sink_en_r;
  assign sink_fire = ~|held(sink_lock_r, sink_lvl, sink_en_r) && |sink_edge;
  assign port_lvl = ~(port_s2_r ^ {8{port_pol_r}});
  assign port_en_eff = par_en_r ? 8'h00 : port_en_r;
  assign port_edge = port_lvl & ~port_lvl_d_r & port_en_eff;
  assign port_fire = ~|held(port_lock_r, port_lvl, port_en_eff) && |port_edge;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sink_lvl_d_r <= 8'h00;
      sink_lock_r <= 8'h00;
      port_lvl_d_r <= 8'h00;
      port_lock_r <= 8'h00;
    end else begin
      sink_lvl_d_r <= sink_lvl;
      port_lvl_d_r <= port_lvl;
      // a held lock releases pin by pin; a free group takes every new edge at once
      if (|held(sink_lock_r, sink_lvl, sink_en_r)) begin
        sink_lock_r <= held(sink_lock_r, sink_lvl, sink_en_r);
      end else begin
        sink_lock_r <= sink_edge;
      end
      if (|held(port_lock_r, port_lvl, port_en_eff)) begin
        port_lock_r <= held(port_lock_r, port_lvl, port_en_eff);
      end else begin
        port_lock_r <= port_edge;
      end
    end
  end

  // source events into pending flops; index is vector number minus one
  always_comb begin
    evt = 12'h000;
    evt[usb_irq_pkg::V_BUSRST - 1] = busrst_end;
    evt[usb_irq_pkg::V_T128 - 1] = tick128;
    evt[usb_irq_pkg::V_T1MS - 1] = tick1ms;
    // only handshakes count, so an unacknowledged in never sets a flop
    for (int i = 0; i < 5; i++) begin
      evt[usb_irq_pkg::V_EP0 - 1 + i] = i_ep_host_ack[i] || i_ep_dev_ack[i];
    end
    evt[usb_irq_pkg::V_SINK - 1] = sink_fire;
    evt[usb_irq_pkg::V_PORT - 1] = par_en_r ? i_par_evt : port_fire;
    evt[usb_irq_pkg::V_I2C - 1] = i_i2c_evt;
  end

  // enable bit per vector; the reserved slot never requests
  always_comb begin
    en_vec = 12'h000;
    en_vec[usb_irq_pkg::V_BUSRST - 1] = gie_en_r[usb_irq_pkg::GE_BUSRST];
    en_vec[usb_irq_pkg::V_T128 - 1] = gie_en_r[usb_irq_pkg::GE_T128];
    en_vec[usb_irq_pkg::V_T1MS - 1] = gie_en_r[usb_irq_pkg::GE_T1MS];
    en_vec[usb_irq_pkg::V_EP0 + 4 - 1 -: 5] = ep_en_r[4:0];
    en_vec[usb_irq_pkg::V_SINK - 1] = gie_en_r[usb_irq_pkg::GE_SINK];
    en_vec[usb_irq_pkg::V_PORT - 1] = gie_en_r[usb_irq_pkg::GE_PORT];
    en_vec[usb_irq_pkg::V_I2C - 1] = gie_en_r[usb_irq_pkg::GE_I2C];
  end
  assign req = pend_r & en_vec;
  assign top_vec = first_vec(req);
  assign take = (st_r == usb_irq_pkg::ST_IDLE) && i_instr_done && gie_r && |req;
  assign pend_clr = (st_r == usb_irq_pkg::ST_CALL && cnt_r == 4'h0) ?
                    12'(12'h001 << (win_r - 4'h1)) : 12'h000;

  // pending flops hold until serviced; a new event beats the acknowledge clear
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_r <= 12'h000;
    end else begin
      pend_r <= (pend_r & ~pend_clr) | evt;
    end
  end

  // core global enable: enable and disable instructions, cleared first on entry
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gie_r <= 1'b0;
    end else if (take || i_gie_clr) begin
      gie_r <= 1'b0;
    end else if (i_gie_set) begin
      gie_r <= 1'b1;
    end
  end

  // acknowledge sequencer: clear flop and push, call cycles, then the slot jump
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= usb_irq_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      win_r <= 4'h0;
      o_call_push <= 1'b0;
      o_isr_start <= 1'b0;
      o_fetch <= '0;
      rst_done_r <= 1'b0;
    end else begin
      o_call_push <= 1'b0;
      o_isr_start <= 1'b0;
      o_fetch.valid <= 1'b0;
      rst_done_r <= 1'b1;
      if (!rst_done_r) begin
        o_fetch.valid <= 1'b1;
        o_fetch.addr <= usb_irq_pkg::RESET_ADDR;
      end
      case (st_r)
        usb_irq_pkg::ST_IDLE: begin
          if (take) begin
            win_r <= top_vec;
            cnt_r <= 4'h0;
            st_r <= usb_irq_pkg::ST_CALL;
          end
        end
        usb_irq_pkg::ST_CALL: begin
          // pushes pc with carry_flag and zero_flag in the core
          o_call_push <= cnt_r == 4'h0;
          if (int'(cnt_r) == usb_irq_pkg::CALL_CYC - 1) begin
            cnt_r <= 4'h0;
            st_r <= usb_irq_pkg::ST_JUMP;
            o_fetch.valid <= 1'b1;
            o_fetch.addr <= {9'h000, win_r, 1'b0};
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        usb_irq_pkg::ST_JUMP: begin
          if (int'(cnt_r) == usb_irq_pkg::JUMP_CYC - 1) begin
            cnt_r <= 4'h0;
            st_r <= usb_irq_pkg::ST_IDLE;
            o_isr_start <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: begin
          st_r <= usb_irq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // apb: no wait state; pready is high in the first access cycle, read data and pready come from flops
  assign wr_acc = i_psel && i_penable && o_pready && i_pwrite;
  assign wd = i_pwdata[7:0];
  always_comb begin
    rd = 8'h00;
    rd_ok = 1'b1;
    if (hit(i_paddr, usb_irq_pkg::IDX_GIE)) begin
      rd = gie_en_r;
    end else if (hit(i_paddr, usb_irq_pkg::IDX_EPE)) begin
      rd = ep_en_r;
    end else if (hit(i_paddr, usb_irq_pkg::IDX_VEC)) begin
      rd = {3'b000, top_vec, 1'b0};
    end else if (hit(i_paddr, usb_irq_pkg::IDX_STAT)) begin
      rd[usb_irq_pkg::ST_IRQ] = |pend_r;
      rd[usb_irq_pkg::ST_BUSRST] = busrst_flag_r;
      rd[usb_irq_pkg::ST_GIE] = gie_r;
    end else if (hit(i_paddr, usb_irq_pkg::IDX_CFG)) begin
      rd[usb_irq_pkg::CF_PAR] = par_en_r;
      rd[usb_irq_pkg::CF_PPOL] = port_pol_r;
    end else if (hit(i_paddr, usb_irq_pkg::IDX_SINKE)) begin
      rd = sink_en_r;
    end else if (hit(i_paddr, usb_irq_pkg::IDX_SINKP)) begin
      rd = sink_pol_r;
    end else if (hit(i_paddr, usb_irq_pkg::IDX_PORTE)) begin
      rd = port_en_r;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !rd_ok;
      if (i_psel && !i_penable && !i_pwrite) begin
        o_prdata <= {24'h00_0000, rd};
      end
    end
  end

  // software-written enables; acknowledge never touches them
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gie_en_r <= 8'h00;
      ep_en_r <= 8'h00;
      sink_en_r <= 8'h00;
      sink_pol_r <= 8'h00;
      port_en_r <= 8'h00;
      par_en_r <= 1'b0;
      port_pol_r <= 1'b0;
    end else if (wr_acc) begin
      if (hit(i_paddr, usb_irq_pkg::IDX_GIE)) begin
        gie_en_r <= wd & usb_irq_pkg::GIE_MASK;
      end
      if (hit(i_paddr, usb_irq_pkg::IDX_EPE)) begin
        ep_en_r <= wd & usb_irq_pkg::EPE_MASK;
      end
      if (hit(i_paddr, usb_irq_pkg::IDX_SINKE)) begin
        sink_en_r <= wd;
      end
      if (hit(i_paddr, usb_irq_pkg::IDX_SINKP)) begin
        sink_pol_r <= wd;
      end
      if (hit(i_paddr, usb_irq_pkg::IDX_PORTE)) begin
        port_en_r <= wd;
      end
      if (hit(i_paddr, usb_irq_pkg::IDX_CFG)) begin
        par_en_r <= wd[usb_irq_pkg::CF_PAR];
        port_pol_r <= wd[usb_irq_pkg::CF_PPOL];
      end
    end
  end

  // bus reset status flag: writing 0 clears, recognition wins over the clear
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busrst_flag_r <= 1'b0;
    end else if (busrst_hit) begin
      busrst_flag_r <= 1'b1;
    end else if (wr_acc && hit(i_paddr, usb_irq_pkg::IDX_STAT) && !wd[usb_irq_pkg::ST_BUSRST]) begin
      busrst_flag_r <= 1'b0;
    end
  end

  // registered views for the core and the port output logic
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_gie <= 1'b0;
      o_irq_req <= 1'b0;
      o_port_int_en <= 8'h00;
    end else begin
      o_gie <= gie_r;
      o_irq_req <= |req;
      o_port_int_en <= port_en_r;
    end
  end
endmodule

// ===== usb_irq_ctrl_properties.sv
// timing and sequencing checks on the interrupt controller ports
// assumes one clock domain and the asynchronous active-low reset of the top module
module usb_irq_ctrl_properties (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic i_usb_dp,
  input wire logic i_usb_dm,
  input wire logic o_dev_addr_clr,
  input wire logic o_startup_abort,
  input wire logic i_instr_done,
  input wire logic o_gie,
  input wire logic o_irq_req,
  input wire logic o_call_push,
  input wire usb_irq_pkg::fetch_t o_fetch,
  input wire logic o_isr_start
);
  logic [1:0] age_r;
  logic take;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);
  // age since reset; the boot fetch is only expected in the first cycle
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      age_r <= 2'b00;
    end else if (age_r != 2'b10) begin
      age_r <= age_r + 2'b01;
    end
  end
  // acknowledge is taken at an instruction boundary with a live request
  assign take = i_instr_done && o_gie && o_irq_req;
  AST_BOOT_FETCH: assert property (age_r == 2'b01 |-> o_fetch.valid && o_fetch.addr == 14'h0000)
    else $error("boot fetch missing or not at address zero");
  AST_APB_READY: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready in first access cycle");
  AST_GIE_DROP: assert property (take |-> ##2 !o_gie)
    else $error("global enable not cleared on acknowledge");
  AST_CALL_PUSH: assert property (take |-> ##2 o_call_push)
    else $error("call push not two cycles after take");
  AST_FETCH_AT: assert property (take |-> ##11 (o_fetch.valid && !o_fetch.addr[0]))
    else $error("vector fetch late or odd");
  AST_ISR_AT: assert property (take |-> ##16 o_isr_start)
    else $error("service routine start not 16 cycles after take");
  AST_JUMP_GAP: assert property (o_fetch.valid && age_r == 2'b10 |-> ##5 o_isr_start)
    else $error("jump slot not five cycles");
  AST_VEC_RANGE: assert property (o_fetch.valid && age_r == 2'b10 |->
    o_fetch.addr >= 14'h0002 && o_fetch.addr <= 14'h0018)
    else $error("vector fetch outside table");
  AST_SE0_CAUSE: assert property (o_dev_addr_clr |-> !$past(i_usb_dp, 8) && !$past(i_usb_dm, 8))
    else $error("address clear without long se0");
  AST_ABORT_PAIR: assert property (o_startup_abort |-> o_dev_addr_clr)
    else $error("start-up abort without bus reset");
endmodule
bind usb_irq_ctrl usb_irq_ctrl_properties chk_i (.i_sys_clk, .i_arst_n, .i_psel, .i_penable,
  .o_pready, .i_usb_dp, .i_usb_dm, .o_dev_addr_clr, .o_startup_abort, .i_instr_done, .o_gie,
  .o_irq_req, .o_call_push, .o_fetch, .o_isr_start);

// ===== core_model.sv
// behavioural processor core on the acknowledge side of the interrupt controller
// assumes the controller clock and reset; the bench asks for enable or disable instructions
module core_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ei,
  input wire logic i_di,
  output logic o_instr_done,
  output logic o_gie_set,
  output logic o_gie_clr
);
  logic [1:0] phase_r;
  // three-cycle instructions, so a request often waits out the rest of one
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_r <= 2'b00;
      o_instr_done <= 1'b0;
    end else begin
      phase_r <= (phase_r == 2'b10) ? 2'b00 : phase_r + 2'b01;
      o_instr_done <= (phase_r == 2'b10);
    end
  end
  // enable only on request, so the vector is read while global enable is clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_gie_set <= 1'b0;
      o_gie_clr <= 1'b0;
    end else begin
      o_gie_set <= i_ei;
      o_gie_clr <= i_di;
    end
  end
endmodule

// ===== usb_mcu_interrupt_vectoring_tb.sv
// self-checking bench: registers, priority, sources and acknowledge of the controller
// assumes core_model on the acknowledge side and the checker bound to the controller
module usb_mcu_interrupt_vectoring_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk, i_arst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, er;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic i_usb_dp, i_usb_dm, i_startup_busy, o_dev_addr_clr, o_startup_abort;
  logic [4:0] i_ep_host_ack, i_ep_dev_ack;
  logic i_i2c_evt, i_par_evt, i_instr_done, i_gie_set, i_gie_clr, ei, di;
  logic [7:0] i_sink_pin, i_port_pin, o_port_int_en;
  logic o_gie, o_irq_req, o_call_push, o_isr_start;
  usb_irq_pkg::fetch_t o_fetch;
  int failures, total_checks;
  usb_irq_ctrl uut (.i_sys_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_pready, .o_prdata, .o_pslverr, .i_usb_dp, .i_usb_dm, .i_startup_busy, .o_dev_addr_clr,
    .o_startup_abort, .i_ep_host_ack, .i_ep_dev_ack, .i_i2c_evt, .i_par_evt, .i_sink_pin,
    .i_port_pin, .o_port_int_en, .i_instr_done, .i_gie_set, .i_gie_clr, .o_gie, .o_irq_req,
    .o_call_push, .o_fetch, .o_isr_start);
  core_model cm (.i_clk(i_sys_clk), .i_arst_n, .i_ei(ei), .i_di(di),
    .o_instr_done(i_instr_done), .o_gie_set(i_gie_set), .o_gie_clr(i_gie_clr));
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  task automatic final_report();
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  // one apb transfer; holds the request until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= {2'b00, idx, 2'b00};
    i_pwdata <= {24'h00_0000, wd};
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (o_pready !== 1'b1) failures++;
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rv(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h00_0000, e});
  endtask
  task automatic vec(input logic [7:0] e);
    rv(usb_irq_pkg::IDX_VEC, e);
  endtask
  // enable once, let the core take the top source, follow call and jump
  task automatic svc(input logic [7:0] ea);
    int n;
    ei <= 1'b1;
    @(posedge i_sys_clk);
    ei <= 1'b0;
    n = 0;
    while (o_fetch.valid !== 1'b1 && n < 64) begin
      @(posedge i_sys_clk);
      n++;
    end
    chk({17'h0_0000, o_fetch}, {17'h0_0000, 1'b1, 6'h00, ea});
    n = 0;
    while (o_isr_start !== 1'b1 && n < 64) begin
      @(posedge i_sys_clk);
      n++;
    end
    chk(32'(n), 32'h0000_0005);
  endtask
  task automatic wirq();
    int n;
    n = 0;
    while (o_irq_req !== 1'b1 && n < 25000) begin
      @(posedge i_sys_clk);
      n++;
    end
    chk({31'h0000_0000, o_irq_req}, 32'h0000_0001);
  endtask
  task automatic t_regs();
    wr(usb_irq_pkg::IDX_GIE, 8'hff);
    rv(usb_irq_pkg::IDX_GIE, 8'h77);
    wr(usb_irq_pkg::IDX_EPE, 8'hff);
    rv(usb_irq_pkg::IDX_EPE, 8'h1f);
    wr(usb_irq_pkg::IDX_VEC, 8'h0c);
    vec(8'h00);
    apb(1'b0, 8'h3f, 8'h00);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    wr(usb_irq_pkg::IDX_GIE, 8'h00);
    wr(usb_irq_pkg::IDX_EPE, 8'h00);
  endtask
  // endpoints and serial source pending together, served in vector order
  task automatic t_prio();
    logic [7:0] ex [6] = '{8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10, 8'h18};
    i_ep_dev_ack <= 5'h1b;
    i_ep_host_ack <= 5'h04;
    i_i2c_evt <= 1'b1;
    cyc(1);
    i_ep_dev_ack <= 5'h00;
    i_ep_host_ack <= 5'h00;
    i_i2c_evt <= 1'b0;
    cyc(2);
    vec(8'h00);
    wr(usb_irq_pkg::IDX_EPE, 8'h1f);
    wr(usb_irq_pkg::IDX_GIE, 8'h40);
    foreach (ex[i]) begin
      vec(ex[i]);
      svc(ex[i]);
    end
    vec(8'h00);
    wr(usb_irq_pkg::IDX_GIE, 8'h00);
  endtask
  // a second sink pin stays blocked while the first is still at trigger level
  task automatic t_sink();
    wr(usb_irq_pkg::IDX_SINKE, 8'h03);
    wr(usb_irq_pkg::IDX_SINKP, 8'h03);
    wr(usb_irq_pkg::IDX_GIE, 8'h10);
    i_sink_pin <= 8'h01;
    cyc(6);
    vec(8'h14);
    svc(8'h14);
    i_sink_pin <= 8'h03;
    cyc(6);
    vec(8'h00);
    rv(usb_irq_pkg::IDX_SINKE, 8'h03);
    i_sink_pin <= 8'h00;
    cyc(6);
    i_sink_pin <= 8'h02;
    cyc(6);
    vec(8'h14);
    svc(8'h14);
    wr(usb_irq_pkg::IDX_GIE, 8'h00);
  endtask
  // port pins, then the parallel port taking over the shared vector
  task automatic t_port();
    wr(usb_irq_pkg::IDX_PORTE, 8'h01);
    wr(usb_irq_pkg::IDX_CFG, 8'h02);
    wr(usb_irq_pkg::IDX_GIE, 8'h20);
    i_port_pin <= 8'h01;
    cyc(6);
    vec(8'h16);
    svc(8'h16);
    chk({24'h00_0000, o_port_int_en}, 32'h0000_0001);
    i_port_pin <= 8'h00;
    wr(usb_irq_pkg::IDX_CFG, 8'h03);
    i_port_pin <= 8'h01;
    cyc(6);
    vec(8'h00);
    i_par_evt <= 1'b1;
    cyc(1);
    i_par_evt <= 1'b0;
    cyc(2);
    vec(8'h16);
    svc(8'h16);
    chk({24'h00_0000, o_port_int_en}, 32'h0000_0001);
    wr(usb_irq_pkg::IDX_GIE, 8'h00);
    wr(usb_irq_pkg::IDX_CFG, 8'h00);
  endtask
  // 17 us of se0 during the start-up delay; interrupt only after it ends
  task automatic t_busrst();
    logic ab, ac;
    ab = 1'b0;
    ac = 1'b0;
    wr(usb_irq_pkg::IDX_GIE, 8'h01);
    i_startup_busy <= 1'b1;
    i_usb_dp <= 1'b0;
    repeat (340) begin
      @(posedge i_sys_clk);
      ab = ab | o_startup_abort;
      ac = ac | o_dev_addr_clr;
    end
    chk({30'h0000_0000, ab, ac}, 32'h0000_0003);
    vec(8'h00);
    apb(1'b0, usb_irq_pkg::IDX_STAT, 8'h00);
    chk(rd & 32'h0000_0020, 32'h0000_0020);
    i_usb_dp <= 1'b1;
    i_startup_busy <= 1'b0;
    cyc(8);
    vec(8'h02);
    svc(8'h02);
    wr(usb_irq_pkg::IDX_STAT, 8'h00);
    wr(usb_irq_pkg::IDX_GIE, 8'h00);
  endtask
  // first free-running tick served as it comes, then the period measured between two requests
  task automatic t_tick();
    time t0;
    wr(usb_irq_pkg::IDX_GIE, 8'h02);
    wirq();
    vec(8'h04);
    svc(8'h04);
    wirq();
    t0 = $time;
    svc(8'h04);
    wirq();
    chk(32'(($time - t0) / 50), 32'h0000_0a00);
    svc(8'h04);
    wr(usb_irq_pkg::IDX_GIE, 8'h04);
    wirq();
    vec(8'h06);
    svc(8'h06);
    wr(usb_irq_pkg::IDX_GIE, 8'h00);
    // enable then disable instruction with no enabled source pending, so no take
    ei <= 1'b1;
    cyc(1);
    ei <= 1'b0;
    cyc(3);
    chk({31'h0000_0000, o_gie}, 32'h0000_0001);
    di <= 1'b1;
    cyc(1);
    di <= 1'b0;
    cyc(3);
    chk({31'h0000_0000, o_gie}, 32'h0000_0000);
  endtask
  initial begin
    failures = 0;
    total_checks = 0;
    {i_arst_n, i_psel, i_penable, i_pwrite, i_i2c_evt, i_par_evt, ei, di} = 8'h00;
    {i_usb_dp, i_usb_dm, i_startup_busy} = 3'b100;
    {i_ep_host_ack, i_ep_dev_ack} = 10'h000;
    {i_sink_pin, i_port_pin} = 16'h0000;
    i_paddr = 12'h000;
    i_pwdata = 32'h0000_0000;
    cyc(3);
    i_arst_n <= 1'b1;
    cyc(2);
    chk({17'h0_0000, o_fetch}, 32'h0000_4000);
    t_regs();
    t_prio();
    t_sink();
    t_port();
    t_busrst();
    t_tick();
    final_report();
  end
  // hang guard, well past the longest tick wait
  initial begin
    #4000000;
    failures++;
    final_report();
  end
endmodule
